// ==== verilog/dpio_map.svh ====
// Purpose: register offsets, field positions and reset values of the ports
// Assumes: 32-bit AXI4-Lite words, byte addresses = 4 x register index
// Notes: definitions only
`ifndef DPIO_MAP_SVH
`define DPIO_MAP_SVH
// register indices, byte address is four times the index
`define DPIO_IDX_PA_LATCH 4'h0
`define DPIO_IDX_PB_LATCH 4'h1
`define DPIO_IDX_PA_DIR 4'h4
`define DPIO_IDX_PB_DIR 4'h5
`define DPIO_IDX_KEY_EN 4'h6
`define DPIO_IDX_TIM_CFG 4'h7
`define DPIO_ADDR_LSB 2
`define DPIO_IDX_W 4
// fields
`define DPIO_BUS_CLOCK_OUT_ENABLE_BIT 7
`define DPIO_KEY_LO 1
`define DPIO_KEY_HI 6
`define DPIO_ELS_LO 0
`define DPIO_ELS_HI 1
`define DPIO_PS_LO 4
`define DPIO_PS_HI 6
`define DPIO_PS_EXT 3'h7
`define DPIO_ELS_GPIO 2'h0
// reset values
`define DPIO_RST_DIR_A 8'h00
`define DPIO_RST_DIR_B 4'h0
`define DPIO_RST_KEY 6'h00
`define DPIO_RST_TIM 5'h00
`define DPIO_RESP_OKAY 2'h0
`define DPIO_RESP_SLVERR 2'h2
`define DPIO_ZERO32 32'h00000000
`endif

// ==== verilog/dpio_pkg.sv ====
// Purpose: shared types of the dual parallel port
// Assumes: nothing
// Notes: offsets live in dpio_map.svh
package dpio_pkg;
    typedef logic [7:0] dpio_byte_type;
    typedef logic [31:0] dpio_word_type;
    typedef enum logic [1:0]
    {
        DPIO_W_IDLE = 2'h0,
        DPIO_W_RESP = 2'h1
    } dpio_wstate_type;
endpackage : dpio_pkg

// ==== verilog/dpio_sync.sv ====
// Purpose: two-flop synchroniser for a vector of pin levels
// Assumes: one clock
// Notes: first stage is read only by the second
`timescale 1ns/100ps
`default_nettype none
module dpio_sync #(parameter int WIDTH = 8)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : dpio_sync
`default_nettype wire

// ==== verilog/dpio_pin.sv ====
// Purpose: one pin's output enable and readback selection
// Assumes: override inputs already decided by the caller
// Notes: purely combinational
`timescale 1ns/100ps
`default_nettype none
module dpio_pin
(
    input wire logic dir,
    input wire logic latch,
    input wire logic level,
    input wire logic force_in,
    input wire logic alt_en,
    input wire logic alt_out,
    input wire logic alt_oe,
    output logic pin_out,
    output logic pin_oe,
    output logic rd_bit
);
    // direction decides readback even when the pin is forced in
    assign rd_bit = dir ? latch : level;
    assign pin_out = alt_en ? alt_out : latch;
    assign pin_oe = alt_en ? alt_oe : (dir & ~force_in);
endmodule : dpio_pin
`default_nettype wire

// ==== verilog/dpio_top.sv ====
// Purpose: two general-purpose ports with key, timer and clock-out sharing
// Assumes: AXI4-Lite slave on aclk, 20 MHz, synchronous active-low reset
// Notes: pins are three signals each; pullup enable shown per port A pin
// Operation
// - key enable forces pin input, pulled up
// - key pin read needs direction zero
// - key enable turns pull-up on
// - latch write leaves input level alone
// - port B has four latch bits
// - reset leaves port B latches untouched
// - pin 2 is timer channel when selected
// - pin 3 feeds timer clock when selected
// - direction bit 7 drives bus clock on pin0
// - reset clears bus clock output enable
// - direction one drives, zero releases pin
// - reset clears port B directions
// - port B read: latch or pin level
// - latches always writable
// - port A read: latch or pin level
// - reset clears port A directions
// - reset clears key enables
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "dpio_map.svh"
module dpio_top
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output dpio_pkg::dpio_word_type s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] port_a_in,
    output logic [7:0] port_a_out,
    output logic [7:0] port_a_oe,
    output logic [7:0] port_a_pullup,
    input wire logic [3:0] port_b_in,
    output logic [3:0] port_b_out,
    output logic [3:0] port_b_oe,
    input wire logic bus_clock,
    input wire logic timer_ch0_out,
    input wire logic timer_ch0_oe,
    output logic timer_ch0_pin,
    output logic timer_ext_clock_pin,
    output logic [5:0] key_level
);
    import dpio_pkg::*;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] port_a_latch_q;
    logic [3:0] port_b_latch_q;
    logic [7:0] port_a_direction_q;
    logic [3:0] port_b_direction_q;
    logic bus_clock_out_enable_q;
    logic [6:1] key_irq_enable_q;
    logic [1:0] ch0_edge_level_select_q;
    logic [2:0] timer_prescale_select_q;
    logic [7:0] level_a;
    logic [3:0] level_b;
    logic [7:0] a_out_d;
    logic [7:0] a_oe_d;
    logic [7:0] a_rd;
    logic [3:0] b_out_d;
    logic [3:0] b_oe_d;
    logic [3:0] b_rd;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // sync pin levels
    dpio_sync #(.WIDTH(8)) u_sync_a
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(port_a_in),
        .sync_out(level_a)
    );
    dpio_sync #(.WIDTH(4)) u_sync_b
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(port_b_in),
        .sync_out(level_b)
    );

    // ----------------------------------------
    // pin functions
    // ----------------------------------------
    logic [7:0] key_force;
    assign key_force = {1'b0, key_irq_enable_q, 1'b0};
    wire ch0_active = ch0_edge_level_select_q != `DPIO_ELS_GPIO;
    wire ext_clk_sel = timer_prescale_select_q == `DPIO_PS_EXT;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_port_a
            dpio_pin u_pin
            (
                .dir(port_a_direction_q[gi]),
                .latch(port_a_latch_q[gi]),
                .level(level_a[gi]),
                .force_in(key_force[gi]),
                .alt_en(1'b0),
                .alt_out(1'b0),
                .alt_oe(1'b0),
                .pin_out(a_out_d[gi]),
                .pin_oe(a_oe_d[gi]),
                .rd_bit(a_rd[gi])
            );
        end
        for (gi = 0; gi < 4; gi++)
        begin : g_port_b
            logic alt_en;
            logic alt_out;
            logic alt_oe;
            if (gi == 0)
            begin : g_clk
                assign alt_en = bus_clock_out_enable_q;
                assign alt_out = bus_clock;
                assign alt_oe = 1'b1;
            end
            else if (gi == 2)
            begin : g_ch0
                assign alt_en = ch0_active;
                assign alt_out = timer_ch0_out;
                assign alt_oe = timer_ch0_oe;
            end
            else
            begin : g_plain
                assign alt_en = 1'b0;
                assign alt_out = 1'b0;
                assign alt_oe = 1'b0;
            end
            dpio_pin u_pin
            (
                .dir(port_b_direction_q[gi]),
                .latch(port_b_latch_q[gi]),
                .level(level_b[gi]),
                .force_in(1'b0),
                .alt_en(alt_en),
                .alt_out(alt_out),
                .alt_oe(alt_oe),
                .pin_out(b_out_d[gi]),
                .pin_oe(b_oe_d[gi]),
                .rd_bit(b_rd[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // write channel
    // ----------------------------------------
    logic aw_held_q;
    logic w_held_q;
    logic [`DPIO_IDX_W-1:0] aw_idx_q;
    dpio_word_type wdata_q;
    logic wstrb0_q;
    dpio_wstate_type wstate_q;
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire have_aw = aw_held_q | aw_take;
    wire have_w = w_held_q | w_take;
    wire w_idle = wstate_q == DPIO_W_IDLE;
    wire do_write = w_idle & have_aw & have_w;
    wire [`DPIO_IDX_W-1:0] w_idx = aw_held_q ? aw_idx_q :
        s_axi_awaddr[`DPIO_ADDR_LSB +: `DPIO_IDX_W];
    wire [7:0] w_byte = w_held_q ? wdata_q[7:0] : s_axi_wdata[7:0];
    wire w_en = w_held_q ? wstrb0_q : s_axi_wstrb[0];
    wire wr_pa = do_write & w_en & (w_idx == `DPIO_IDX_PA_LATCH);
    wire wr_pb = do_write & w_en & (w_idx == `DPIO_IDX_PB_LATCH);
    wire wr_da = do_write & w_en & (w_idx == `DPIO_IDX_PA_DIR);
    wire wr_db = do_write & w_en & (w_idx == `DPIO_IDX_PB_DIR);
    wire wr_ke = do_write & w_en & (w_idx == `DPIO_IDX_KEY_EN);
    wire wr_tc = do_write & w_en & (w_idx == `DPIO_IDX_TIM_CFG);
    wire w_hit = (w_idx == `DPIO_IDX_PA_LATCH) |
        (w_idx == `DPIO_IDX_PB_LATCH) | (w_idx == `DPIO_IDX_PA_DIR) |
        (w_idx == `DPIO_IDX_PB_DIR) | (w_idx == `DPIO_IDX_KEY_EN) |
        (w_idx == `DPIO_IDX_TIM_CFG);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_idx_q <= '0;
            wdata_q <= `DPIO_ZERO32;
            wstrb0_q <= 1'b0;
            wstate_q <= DPIO_W_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DPIO_RESP_OKAY;
        end
        else
        begin
            if (aw_take)
                aw_idx_q <= s_axi_awaddr[`DPIO_ADDR_LSB +: `DPIO_IDX_W];
            if (w_take)
            begin
                wdata_q <= s_axi_wdata;
                wstrb0_q <= s_axi_wstrb[0];
            end
            if (do_write)
            begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                wstate_q <= DPIO_W_RESP;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= w_hit ? `DPIO_RESP_OKAY : `DPIO_RESP_SLVERR;
            end
            else
            begin
                aw_held_q <= have_aw;
                w_held_q <= have_w;
                if (s_axi_bvalid && s_axi_bready)
                begin
                    s_axi_bvalid <= 1'b0;
                    wstate_q <= DPIO_W_IDLE;
                end
            end
        end
    end
    // each ready only while its own channel has nothing parked and no response is pending
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            s_axi_awready <= ~have_aw & ~do_write & w_idle;
            s_axi_wready <= ~have_w & ~do_write & w_idle;
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    // clock out cleared
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            port_a_direction_q <= `DPIO_RST_DIR_A;
            port_b_direction_q <= `DPIO_RST_DIR_B;
            bus_clock_out_enable_q <= 1'b0;
            key_irq_enable_q <= `DPIO_RST_KEY;
            {ch0_edge_level_select_q, timer_prescale_select_q} <=
                `DPIO_RST_TIM;
        end
        else
        begin
            if (wr_da)
                port_a_direction_q <= w_byte;
            if (wr_db)
            begin
                port_b_direction_q <= w_byte[3:0];
                bus_clock_out_enable_q <= w_byte[`DPIO_BUS_CLOCK_OUT_ENABLE_BIT];
            end
            if (wr_ke)
                key_irq_enable_q <= w_byte[`DPIO_KEY_HI:`DPIO_KEY_LO];
            if (wr_tc)
            begin
                ch0_edge_level_select_q <=
                    w_byte[`DPIO_ELS_HI:`DPIO_ELS_LO];
                timer_prescale_select_q <= w_byte[`DPIO_PS_HI:`DPIO_PS_LO];
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (wr_pa)
            port_a_latch_q <= w_byte;
        if (wr_pb)
            port_b_latch_q <= w_byte[3:0];
    end

    // ----------------------------------------
    // read channel
    // ----------------------------------------
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire [`DPIO_IDX_W-1:0] r_idx = s_axi_araddr[`DPIO_ADDR_LSB +: `DPIO_IDX_W];
    wire r_pa = r_idx == `DPIO_IDX_PA_LATCH;
    wire r_pb = r_idx == `DPIO_IDX_PB_LATCH;
    wire r_da = r_idx == `DPIO_IDX_PA_DIR;
    wire r_db = r_idx == `DPIO_IDX_PB_DIR;
    wire r_ke = r_idx == `DPIO_IDX_KEY_EN;
    wire r_tc = r_idx == `DPIO_IDX_TIM_CFG;
    wire r_hit = r_pa | r_pb | r_da | r_db | r_ke | r_tc;
    wire [7:0] r_byte =
        r_pa ? a_rd :
        r_pb ? {4'h0, b_rd} :
        r_da ? port_a_direction_q :
        r_db ? {bus_clock_out_enable_q, 3'h0, port_b_direction_q} :
        r_ke ? {1'b0, key_irq_enable_q, 1'b0} :
        r_tc ? {1'b0, timer_prescale_select_q, 2'h0,
            ch0_edge_level_select_q} : 8'h00;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `DPIO_ZERO32;
            s_axi_rresp <= `DPIO_RESP_OKAY;
        end
        else if (ar_take)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, r_byte};
            s_axi_rresp <= r_hit ? `DPIO_RESP_OKAY : `DPIO_RESP_SLVERR;
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
        else
            s_axi_arready <= 1'b1;
    end

    // ----------------------------------------
    // registered pin outputs
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            port_a_out <= 8'h00;
            port_a_oe <= 8'h00;
            port_a_pullup <= 8'h00;
            port_b_out <= 4'h0;
            port_b_oe <= 4'h0;
            timer_ch0_pin <= 1'b0;
            timer_ext_clock_pin <= 1'b0;
            key_level <= 6'h00;
        end
        else
        begin
            port_a_out <= a_out_d;
            port_a_oe <= a_oe_d;
            port_a_pullup <= key_force;
            port_b_out <= b_out_d;
            port_b_oe <= b_oe_d;
            timer_ch0_pin <= level_b[2];
            timer_ext_clock_pin <= ext_clk_sel & level_b[3];
            key_level <= level_a[`DPIO_KEY_HI:`DPIO_KEY_LO] & key_irq_enable_q;
        end
    end
endmodule : dpio_top
`default_nettype wire

// ==== sim/dpio_top_assertions.sv ====
// Purpose: port relations of the dual parallel port
// Assumes: one clock, synchronous active-low reset
// Notes: bound to dpio_top from the testbench
`timescale 1ns/100ps
`default_nettype none
module dpio_top_assertions
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire dpio_pkg::dpio_word_type s_axi_rdata,
    input wire logic [7:0] port_a_oe,
    input wire logic [7:0] port_a_pullup,
    input wire logic [3:0] port_b_oe
);
    import dpio_pkg::*;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    key_pin_input_a: assert property (
        (port_a_pullup & port_a_oe) == 8'h00)
        else $error("pulled-up pin is driven");
    pullup_range_a: assert property (
        port_a_pullup[0] == 1'b0 && port_a_pullup[7] == 1'b0)
        else $error("pull-up on a pin without key function");
    reset_state_a: assert property (
        $past(!aresetn) |-> port_a_oe == 8'h00 && port_b_oe == 4'h0
        && port_a_pullup == 8'h00) else $error("pins not released by reset");
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rdata_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    read_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    write_park_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address taken while response pending");
    read_park_a: assert property (s_axi_rvalid |-> ##1 !s_axi_arready)
        else $error("read address taken while data pending");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property (port_a_pullup != 8'h00);
    cover property (s_axi_bvalid && !s_axi_bready);
endmodule : dpio_top_assertions
`default_nettype wire

// ==== sim/dpio_board_model.sv ====
// Purpose: board side of the port pins
// Assumes: testbench chooses which pins the board drives
// Notes: an undriven line without pull-up toggles every cycle
`timescale 1ns/100ps
`default_nettype none
module dpio_board_model
(
    input wire logic aclk,
    input wire logic [7:0] port_a_out,
    input wire logic [7:0] port_a_oe,
    input wire logic [7:0] port_a_pullup,
    input wire logic [3:0] port_b_out,
    input wire logic [3:0] port_b_oe,
    input wire logic [7:0] drive_a,
    input wire logic [7:0] drive_a_en,
    input wire logic [3:0] drive_b,
    input wire logic [3:0] drive_b_en,
    output logic [7:0] port_a_in,
    output logic [3:0] port_b_in
);
    logic [7:0] float_q = 8'h55;
    // floating lines must not look like a stable level
    always_ff @(posedge aclk)
        float_q <= ~float_q;
    // pull-up lifts an undriven key pin
    assign port_a_in = (port_a_oe & port_a_out)
        | (~port_a_oe & drive_a_en & drive_a)
        | (~port_a_oe & ~drive_a_en & (port_a_pullup | float_q));
    assign port_b_in = (port_b_oe & port_b_out)
        | (~port_b_oe & drive_b_en & drive_b)
        | (~port_b_oe & ~drive_b_en & float_q[3:0]);
endmodule : dpio_board_model
`default_nettype wire

// ==== sim/dpio_top_tb.sv ====
// Purpose: self-checking bench of the dual parallel port
// Assumes: AXI4-Lite master in the bench, board model on the pins
// Notes: one stalled response per channel, one write without byte lane 0
`timescale 1ns/100ps
`default_nettype none
module dpio_top_tb;
    import dpio_pkg::*;
    typedef struct {logic [31:0] a; logic [31:0] d;
        logic [31:0] e;} dpio_row_type;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic arvalid = 1'b0, bready = 1'b1, rready = 1'b1, bus_clock = 1'b0;
    logic tch_out = 1'b1, tch_oe = 1'b1;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, tch_pin, timer_ext_clock_pin_pin;
    logic [1:0] bresp, rresp;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    dpio_word_type rdata;
    logic [7:0] pa_in, pa_out, pa_oe, pa_pu, drv_a = 8'h3C, drv_a_en = 8'hFF;
    logic [3:0] pb_in, pb_out, pb_oe, drv_b = 4'h5, drv_b_en = 4'hF;
    logic [5:0] key_level;
    int errors = 0, checks_done = 0, cycles = 0;
    dpio_row_type rows [6] = '{'{32'h00, 32'hA5, 32'h3C},
        '{32'h10, 32'hFF, 32'hFF}, '{32'h04, 32'h0A, 32'h05},
        '{32'h14, 32'h0F, 32'h0F}, '{32'h18, 32'h7E, 32'h7E},
        '{32'h1C, 32'h03, 32'h03}};
    always #25 aclk = ~aclk;
    dpio_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_a_in(pa_in),
        .port_a_out(pa_out), .port_a_oe(pa_oe), .port_a_pullup(pa_pu),
        .port_b_in(pb_in), .port_b_out(pb_out), .port_b_oe(pb_oe),
        .bus_clock(bus_clock), .timer_ch0_out(tch_out),
        .timer_ch0_oe(tch_oe), .timer_ch0_pin(tch_pin),
        .timer_ext_clock_pin(timer_ext_clock_pin_pin), .key_level(key_level));
    dpio_board_model board (.aclk(aclk), .port_a_out(pa_out),
        .port_a_oe(pa_oe), .port_a_pullup(pa_pu), .port_b_out(pb_out),
        .port_b_oe(pb_oe), .drive_a(drv_a), .drive_a_en(drv_a_en),
        .drive_b(drv_b), .drive_b_en(drv_b_en), .port_a_in(pa_in),
        .port_b_in(pb_in));
    task end_of_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(posedge aclk);
    endtask : tick
    task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end
        while ((awvalid && !awready) || (wvalid && !wready));
        do @(posedge aclk); while (!(bvalid && bready));
        chk(32'(bresp), 32'(er));
    endtask : wr
    task rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!(rvalid && rready));
        chk(rdata, ed);
        chk(32'(rresp), 32'(er));
    endtask : rd
    // a hang counts as a mismatch
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            end_of_test();
        end
    end
    // -------------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------------
    initial
    begin
        tick(20);
        aresetn <= 1'b1;
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d, 2'h0);
            rd(rows[i].a, rows[i].e, 2'h0);
        end
        tick(4);
        chk(32'(pb_oe), 32'hF);
        chk(32'(pb_out), 32'hE);
        rd(32'h04, 32'h0A, 2'h0);
        tch_oe <= 1'b0;
        tick(4);
        chk(32'(pb_oe), 32'hB);
        chk(32'(tch_pin), 32'h1);
        chk(32'(pa_oe), 32'h81);
        chk(32'(pa_pu), 32'h7E);
        rd(32'h00, 32'hA5, 2'h0);
        wr(32'h10, 32'h00, 2'h0);
        drv_a <= 8'h24;
        drv_a_en <= 8'hFF;
        tick(4);
        rd(32'h00, 32'h24, 2'h0);
        chk(32'(key_level), 32'h12);
        drv_a_en <= 8'h81;
        tick(4);
        rd(32'h00, 32'h7E, 2'h0);
        wr(32'h00, 32'h5A, 2'h0);
        rd(32'h00, 32'h7E, 2'h0);
        wr(32'h10, 32'hFF, 2'h0);
        rd(32'h00, 32'h5A, 2'h0);
        wstrb <= 4'h0;
        wr(32'h00, 32'hC3, 2'h0);
        wstrb <= 4'hF;
        rd(32'h00, 32'h5A, 2'h0);
        wr(32'h14, 32'h00, 2'h0);
        drv_b <= 4'h8;
        wr(32'h1C, 32'h70, 2'h0);
        tick(4);
        chk(32'(timer_ext_clock_pin_pin), 32'h1);
        wr(32'h1C, 32'h00, 2'h0);
        tick(4);
        chk(32'(timer_ext_clock_pin_pin), 32'h0);
        wr(32'h14, 32'h80, 2'h0);
        for (int v = 1; v >= 0; v--)
        begin
            bus_clock <= v[0];
            tick(4);
            chk(32'(pb_oe), 32'h1);
            chk(32'(pb_out[0]), 32'(v));
        end
        // responses stand while the master is not ready
        bready <= 1'b0;
        rready <= 1'b0;
        fork
            wr(32'h20, 32'h01, 2'h2);
            begin
                tick(3);
                bready <= 1'b1;
            end
        join
        fork
            rd(32'h20, 32'h00, 2'h2);
            begin
                tick(3);
                rready <= 1'b1;
            end
        join
        aresetn <= 1'b0;
        tick(20);
        aresetn <= 1'b1;
        tick(1);
        chk(32'({pa_oe, pa_pu, pb_oe}), 32'h0);
        rd(32'h14, 32'h00, 2'h0);
        rd(32'h18, 32'h00, 2'h0);
        wr(32'h14, 32'h0F, 2'h0);
        rd(32'h04, 32'h0A, 2'h0);
        end_of_test();
    end
endmodule : dpio_top_tb
bind dpio_top dpio_top_assertions u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .port_a_oe(port_a_oe),
    .port_a_pullup(port_a_pullup), .port_b_oe(port_b_oe));
`default_nettype wire
